// file: clc_pkg.sv
// Shared constants and types for the configurable logic cell.
package clc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int DATA_W     = 8;
  localparam int PLD_COUNT  = 2;
  localparam int PLD_IN_W   = 12;
  localparam int PLD_TERMS  = 8;
  localparam int PLD_OUTS   = 4;
  localparam int CFG_WORDS  = 8;
  localparam int CFG_ADDR_W = 3;
  localparam int FQ_DEPTH   = 4;

  // ****************************************
  // Register selects on the system bus port
  // ****************************************
  localparam logic [1:0][2:0] SEL_ACC = {3'h1, 3'h0};  // Accumulator one, zero.
  localparam logic [1:0][2:0] SEL_DAT = {3'h3, 3'h2};  // Data operand one, zero.
  localparam logic [1:0][2:0] SEL_FQ  = {3'h5, 3'h4};  // Bus queue one, zero.

  // ****************************************
  // Reset values and fixed constants
  // ****************************************
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONES = 8'hFF;
  localparam logic [8:0]  ALU_ONE   = 9'h001;
  localparam logic [15:0] CFG_RESET = 16'h0007;  // Pass-through, nothing written.

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    FN_INC = 3'h0, FN_DEC = 3'h1, FN_ADD = 3'h2, FN_SUB = 3'h3,
    FN_AND = 3'h4, FN_OR  = 3'h5, FN_XOR = 3'h6, FN_PASS = 3'h7
  } clc_func_e;

  typedef struct packed {
    logic      f1_alt;   // Queue one uses accumulator one instead of data/ALU.
    logic      f0_alt;   // Queue zero uses accumulator zero instead of data/ALU.
    logic      f1_op;    // Queue one moves a byte this cycle.
    logic      f0_op;    // Queue zero moves a byte this cycle.
    logic      alu_a1;   // ALU result is written to accumulator one.
    logic      alu_a0;   // ALU result is written to accumulator zero.
    logic      mask_en;  // OR the mask value into the result.
    logic      swap;     // Swap nibbles of the result.
    logic      shr;      // Shift result right.
    logic      shl;      // Shift result left.
    logic [1:0] srcb;    // Operand B: 0 acc zero, 1 acc one, 2 data zero, 3 data one.
    logic      srca;     // Operand A: accumulator zero or one.
    clc_func_e func;
  } clc_dp_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } clc_bus_req_s;

  typedef struct packed {
    logic [PLD_TERMS-1:0][PLD_IN_W-1:0] pt_true;
    logic [PLD_TERMS-1:0][PLD_IN_W-1:0] pt_comp;
    logic [PLD_OUTS-1:0][PLD_TERMS-1:0] or_mask;
    logic [PLD_OUTS-1:0]                out_reg;
  } clc_pld_cfg_s;

  typedef struct packed {
    logic       ovf;
    logic [1:0] ones;
    logic [1:0] zero;
    logic [1:0] cmp_lt;
    logic [1:0] cmp_eq;
  } clc_cond_s;

endpackage

// file: clc_cell.sv
// Configurable logic cell: two sum-of-products arrays and an 8-bit datapath.
//
// Function
// [RULE1] Cell holds two independent product-term arrays beside its datapath.
// [RULE2] Array outputs come from routing inputs, each registered or combinational.
// [RULE3] Each array has 12 inputs, all reaching its eight product terms.
// [RULE4] A product term ANDs any 1 to 12 array inputs.
// [RULE5] Each participating input is used true or inverted.
// [RULE6] Each array output ORs any 1 to 8 product terms.
// [RULE7] Every output sees all eight product terms.
// [RULE8] Inputs and outputs are fully interchangeable; the array is symmetric.
// [RULE9] An 8-bit ALU does one operation per cycle, with compares and conditions.
// [RULE10] Six working registers are reachable by the bus during operation.
// [RULE11] Accumulators are ALU operands, ALU destinations and compare operands.
// [RULE12] Data registers are ALU and compare operands, never ALU destinations.
// [RULE13] Two queues link bus and datapath, each four bytes deep.
// [RULE14] A queue loads data or accumulators, or captures accumulator or ALU result.
// [RULE15] Each queue is separately an input or an output buffer.
// [RULE16] Operation comes each cycle from an 8x16 store indexed by routing.
// [RULE17] Eight ALU functions plus independent shift, nibble swap and OR mask.
// [RULE18] Reset empties queues and clears registered array outputs.
`timescale 1ns/10ps
module clc_cell #(
  parameter int FQ_DEPTH = clc_pkg::FQ_DEPTH
) (
  input  wire logic                                                clk_sys,
  input  wire logic                                                rst,
  input  wire clc_pkg::clc_bus_req_s                               bus_req,
  output logic [7:0]                                               bus_rdata,
  output logic                                                     bus_rvalid,
  input  wire logic                                                cfg_wr,
  input  wire logic [clc_pkg::CFG_ADDR_W-1:0]                      cfg_addr,
  input  wire clc_pkg::clc_dp_cfg_s                                cfg_data,
  input  wire logic [clc_pkg::CFG_ADDR_W-1:0]                      dp_addr,
  input  wire logic [1:0]                                          fq_dir,
  input  wire logic [7:0]                                          mask_value,
  input  wire clc_pkg::clc_pld_cfg_s [clc_pkg::PLD_COUNT-1:0]      pld_cfg,
  input  wire logic [clc_pkg::PLD_COUNT-1:0][clc_pkg::PLD_IN_W-1:0] pld_in,
  output logic [clc_pkg::PLD_COUNT-1:0][clc_pkg::PLD_OUTS-1:0]     pld_out,
  output clc_pkg::clc_cond_s                                       cond,
  output logic [1:0]                                               fq_empty,
  output logic [1:0]                                               fq_full
);

  localparam int PW = $clog2(FQ_DEPTH);
  localparam int CW = $clog2(FQ_DEPTH + 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_FULL = CW'(FQ_DEPTH);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);

  // ****************************************
  // Functions
  // ****************************************
  // Eight ALU functions with carry or borrow in bit eight.
  function automatic logic [8:0] clc_alu(input clc_pkg::clc_func_e f,
                                         input logic [7:0] a, input logic [7:0] b);
    case (f)
      clc_pkg::FN_INC: return {1'b0, a} + clc_pkg::ALU_ONE;
      clc_pkg::FN_DEC: return {1'b0, a} - clc_pkg::ALU_ONE;
      clc_pkg::FN_ADD: return {1'b0, a} + {1'b0, b};
      clc_pkg::FN_SUB: return {1'b0, a} - {1'b0, b};
      clc_pkg::FN_AND: return {1'b0, a & b};
      clc_pkg::FN_OR:  return {1'b0, a | b};
      clc_pkg::FN_XOR: return {1'b0, a ^ b};
      default:         return {1'b0, a};
    endcase
  endfunction

  // Bus write decode, used for every register.
  function automatic logic bus_wr_hit(input clc_pkg::clc_bus_req_s r, input logic [2:0] code);
    return r.wr && (r.sel == code);
  endfunction

  // ****************************************
  // Product-term arrays
  // ****************************************
  logic [clc_pkg::PLD_COUNT-1:0][clc_pkg::PLD_OUTS-1:0] pld_sum;
  logic [clc_pkg::PLD_COUNT-1:0][clc_pkg::PLD_OUTS-1:0] pld_q_reg;

  // [RULE1] two arrays built
  for (genvar gp = 0; gp < clc_pkg::PLD_COUNT; gp++) begin : g_pld
    logic [clc_pkg::PLD_TERMS-1:0] pterm;
    // [RULE3] inputs to terms
    for (genvar gt = 0; gt < clc_pkg::PLD_TERMS; gt++) begin : g_term
      // [RULE4] configurable AND width
      // [RULE5] true or complement
      assign pterm[gt] = &((~pld_cfg[gp].pt_true[gt] | pld_in[gp])
                         & (~pld_cfg[gp].pt_comp[gt] | ~pld_in[gp]));
    end
    // [RULE6] configurable OR width
    // [RULE7] constant OR width
    // [RULE8] symmetric identical slices
    for (genvar go = 0; go < clc_pkg::PLD_OUTS; go++) begin : g_out
      assign pld_sum[gp][go] = |(pterm & pld_cfg[gp].or_mask[go]);
    end
    // [RULE2] registered or combinational
    assign pld_out[gp] = (pld_cfg[gp].out_reg & pld_q_reg[gp])
                       | (~pld_cfg[gp].out_reg & pld_sum[gp]);
  end

  // Registered copy of every array output.
  // [RULE18] clear registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pld_q_reg <= '0;
    end else begin
      pld_q_reg <= pld_sum;
    end
  end

  // ****************************************
  // Configuration store
  // ****************************************
  logic [15:0]          cfg_ram [clc_pkg::CFG_WORDS];
  clc_pkg::clc_dp_cfg_s cur;

  // Store written from the configuration port.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < clc_pkg::CFG_WORDS; i++) cfg_ram[i] <= clc_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_ram[cfg_addr] <= cfg_data;
    end
  end

  // [RULE16] per-cycle operation select
  assign cur = clc_pkg::clc_dp_cfg_s'(cfg_ram[dp_addr]);

  // ****************************************
  // ALU
  // ****************************************
  logic [1:0][7:0] acc_reg, acc_next, dat_reg, dat_next;
  logic [7:0]      opa, opb, shifted, swapped, alu_final;
  logic [8:0]      alu_raw;

  // [RULE11] accumulator as operand
  assign opa = acc_reg[cur.srca];
  assign opb = cur.srcb[1] ? dat_reg[cur.srcb[0]] : acc_reg[cur.srcb[0]];
  // [RULE9] single-cycle ALU
  assign alu_raw = clc_alu(cur.func, opa, opb);
  // [RULE17] shift, swap, mask
  assign shifted = cur.shl ? {alu_raw[6:0], 1'b0} :
                   cur.shr ? {1'b0, alu_raw[7:1]} : alu_raw[7:0];
  assign swapped   = cur.swap ? {shifted[3:0], shifted[7:4]} : shifted;
  assign alu_final = cur.mask_en ? (swapped | mask_value) : swapped;

  // ****************************************
  // Bus queues
  // ****************************************
  logic [7:0]          fq_mem [2][FQ_DEPTH];
  logic [1:0][PW-1:0]  fq_wp_reg, fq_rp_reg;
  logic [1:0][CW-1:0]  fq_cnt_reg, fq_cnt_next;
  logic [1:0]          fq_push, fq_pop, dp_load;
  logic [1:0][7:0]     fq_din, fq_head;

  for (genvar gq = 0; gq < 2; gq++) begin : g_fq
    logic op;
    logic alt;
    assign op  = gq ? cur.f1_op : cur.f0_op;
    assign alt = gq ? cur.f1_alt : cur.f0_alt;
    // [RULE15] direction per queue
    assign fq_push[gq] = (fq_dir[gq] ? op : bus_wr_hit(bus_req, clc_pkg::SEL_FQ[gq]))
                       && (fq_cnt_reg[gq] != CNT_FULL);
    assign fq_pop[gq]  = (fq_dir[gq] ? (bus_req.rd && bus_req.sel == clc_pkg::SEL_FQ[gq]) : op)
                       && (fq_cnt_reg[gq] != CNT_ZERO);
    // [RULE14] capture accumulator or ALU
    assign fq_din[gq]  = ~fq_dir[gq] ? bus_req.wdata : (alt ? acc_reg[gq] : alu_final);
    assign dp_load[gq] = fq_pop[gq] && ~fq_dir[gq];
    assign fq_head[gq] = fq_mem[gq][fq_rp_reg[gq]];
    assign fq_cnt_next[gq] = fq_cnt_reg[gq] + (fq_push[gq] ? CNT_ONE : CNT_ZERO)
                                            - (fq_pop[gq] ? CNT_ONE : CNT_ZERO);

    // [RULE13] four-byte queue
    always_ff @(posedge clk_sys) begin
      if (fq_push[gq]) fq_mem[gq][fq_wp_reg[gq]] <= fq_din[gq];
    end

    // Pointers, count and flags; flags track the next count so they come from flops.
    // [RULE18] reset empties queue
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        fq_wp_reg[gq]  <= '0;
        fq_rp_reg[gq]  <= '0;
        fq_cnt_reg[gq] <= CNT_ZERO;
        fq_empty[gq]   <= 1'b1;
        fq_full[gq]    <= 1'b0;
      end else begin
        fq_wp_reg[gq]  <= fq_wp_reg[gq] + (fq_push[gq] ? PTR_ONE : '0);
        fq_rp_reg[gq]  <= fq_rp_reg[gq] + (fq_pop[gq] ? PTR_ONE : '0);
        fq_cnt_reg[gq] <= fq_cnt_next[gq];
        fq_empty[gq]   <= fq_cnt_next[gq] == CNT_ZERO;
        fq_full[gq]    <= fq_cnt_next[gq] == CNT_FULL;
      end
    end

    // ****************************************
    // Working register next values
    // ****************************************
    // Bus write wins, then a queue load, then the ALU result.
    // [RULE10] bus access to registers
    assign acc_next[gq] = bus_wr_hit(bus_req, clc_pkg::SEL_ACC[gq]) ? bus_req.wdata :
                          (dp_load[gq] && alt) ? fq_head[gq] :
                          // [RULE11] accumulator as destination
                          (gq ? cur.alu_a1 : cur.alu_a0) ? alu_final : acc_reg[gq];
    // [RULE12] data never ALU destination
    assign dat_next[gq] = bus_wr_hit(bus_req, clc_pkg::SEL_DAT[gq]) ? bus_req.wdata :
                          (dp_load[gq] && !alt) ? fq_head[gq] : dat_reg[gq];
  end

  // Working registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      dat_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      dat_reg <= dat_next;
    end
  end

  // ****************************************
  // Conditions and bus read
  // ****************************************
  clc_pkg::clc_cond_s cond_next;
  logic [7:0]         rdata_next;

  // [RULE9] compare and condition logic
  assign cond_next.cmp_eq = {acc_reg[1] == dat_reg[1], acc_reg[0] == dat_reg[0]};
  assign cond_next.cmp_lt = {acc_reg[1] <  dat_reg[1], acc_reg[0] <  dat_reg[0]};
  assign cond_next.zero   = {acc_reg[1] == clc_pkg::BYTE_ZERO, acc_reg[0] == clc_pkg::BYTE_ZERO};
  assign cond_next.ones   = {acc_reg[1] == clc_pkg::BYTE_ONES, acc_reg[0] == clc_pkg::BYTE_ONES};
  assign cond_next.ovf    = alu_raw[8];

  // Read mux; an output queue pops on read, other selects return zero.
  assign rdata_next = (bus_req.sel == clc_pkg::SEL_ACC[0]) ? acc_reg[0] :
                      (bus_req.sel == clc_pkg::SEL_ACC[1]) ? acc_reg[1] :
                      (bus_req.sel == clc_pkg::SEL_DAT[0]) ? dat_reg[0] :
                      (bus_req.sel == clc_pkg::SEL_DAT[1]) ? dat_reg[1] :
                      (fq_pop[0] && fq_dir[0])             ? fq_head[0] :
                      (fq_pop[1] && fq_dir[1])             ? fq_head[1] : clc_pkg::BYTE_ZERO;

  // Read answer one cycle after the request, plus registered conditions.
  // [RULE10] bus read answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata  <= clc_pkg::BYTE_ZERO;
      bus_rvalid <= 1'b0;
      cond       <= '0;
    end else begin
      bus_rdata  <= bus_req.rd ? rdata_next : bus_rdata;
      bus_rvalid <= bus_req.rd;
      cond       <= cond_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_rd_req;
    bus_req.rd && bus_req.sel == clc_pkg::SEL_ACC[0];
  endsequence
  sequence s_rd_ans;
    bus_rvalid && bus_rdata == $past(acc_reg[0]);
  endsequence

  AST_RD_ANSWER: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
    s_rd_req |=> s_rd_ans) else $error("Accumulator read answer wrong or late.");
  AST_FQ_DEPTH: assert property (@(posedge clk_sys) disable iff (rst) // [RULE13]
    fq_cnt_reg[0] <= CNT_FULL && (fq_full[0] == (fq_cnt_reg[0] == CNT_FULL)))
    else $error("Queue zero count or full flag wrong.");
  AST_FQ_NO_OVERFILL: assert property (@(posedge clk_sys) disable iff (rst) // [RULE15]
    fq_full[0] && !fq_dir[0] && bus_wr_hit(bus_req, clc_pkg::SEL_FQ[0]) && !fq_pop[0]
    |=> fq_cnt_reg[0] == CNT_FULL) else $error("Full input queue accepted a write.");
  AST_DAT_NOT_ALU: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
    !bus_req.wr && !dp_load[0] |=> $stable(dat_reg[0]))
    else $error("Data operand changed without bus or queue load.");
  AST_ACC_ALU: assert property (@(posedge clk_sys) disable iff (rst) // [RULE11]
    cur.alu_a1 && !bus_req.wr && !dp_load[1] |=> acc_reg[1] == $past(alu_final))
    else $error("Accumulator one missed the ALU result.");
  AST_ALU_ADD: assert property (@(posedge clk_sys) disable iff (rst) // [RULE17]
    cur.func == clc_pkg::FN_ADD && !cur.shl && !cur.shr && !cur.swap && !cur.mask_en
    |-> alu_final == 8'(opa + opb)) else $error("ALU add result wrong.");
  AST_CFG_SELECT: assert property (@(posedge clk_sys) disable iff (rst) // [RULE16]
    cfg_wr ##1 !cfg_wr ##1 (dp_addr == $past(cfg_addr, 2)) |-> cur == $past(cfg_data, 2))
    else $error("Operation not taken from the addressed store word.");
  AST_PLD_REG: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    pld_cfg[1].out_reg[0] ##1 pld_cfg[1].out_reg[0] |-> pld_out[1][0] == $past(pld_sum[1][0]))
    else $error("Registered array output does not lag the sum by one cycle.");
  AST_PLD_OR_ONE: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    pld_cfg[1].or_mask[2] == 8'h01 |-> pld_sum[1][2] == g_pld[1].pterm[0])
    else $error("Single-term array output does not follow its term.");
  AST_RESET_EMPTY: assert property (@(posedge clk_sys) // [RULE18]
    $fell(rst) |-> fq_empty == 2'h3 && fq_cnt_reg[0] == CNT_ZERO && pld_q_reg == '0)
    else $error("Reset left a queue or registered output set.");
  AST_FQ_OUT_DROP: assert property (@(posedge clk_sys) disable iff (rst) // [RULE13]
    fq_full[1] && fq_dir[1] && cur.f1_op && !fq_pop[1] |=> fq_cnt_reg[1] == CNT_FULL)
    else $error("Full output queue accepted a datapath push.");
  AST_DAT_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // [RULE14]
    dp_load[0] && !cur.f0_alt && !bus_wr_hit(bus_req, clc_pkg::SEL_DAT[0])
    |=> dat_reg[0] == $past(fq_head[0])) else $error("Data operand missed the queue head.");

endmodule // clc_cell

// file: clc_bus_host.sv
// Bus host model that stands for the processor and DMA side of the cell.
`timescale 1ns/10ps
module clc_bus_host (
  input  wire logic            clk_sys,
  output clc_pkg::clc_bus_req_s bus_req
);
  // ********
  // Bus cycles
  // ********
  // Lines start idle and low.
  initial begin
    bus_req = '0;
  end

  // Single byte access.
  // The request is held over one sampling edge, then select and data toggle so stale
  // values never look valid.
  task automatic access(input logic wr, input logic rd, input logic [2:0] sel,
                        input logic [7:0] wdata, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    bus_req <= '{wr: wr, rd: rd, sel: sel, wdata: wdata};
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b0, sel: ~sel, wdata: ~wdata};
  endtask
endmodule // clc_bus_host

// file: clc_cell_bench.sv
// Self-checking bench for the configurable logic cell.
`timescale 1ns/10ps
module clc_cell_bench;
  // ********
  // Signals
  // ********
  logic                      clk_sys    = 1'b0;
  logic                      rst        = 1'b1;
  clc_pkg::clc_bus_req_s     bus_req;
  logic [7:0]                bus_rdata;
  logic                      bus_rvalid;
  logic                      cfg_wr     = 1'b0;
  logic [2:0]                cfg_addr   = 3'h0;
  clc_pkg::clc_dp_cfg_s      cfg_data   = clc_pkg::CFG_RESET;
  logic [2:0]                dp_addr    = 3'h7;
  logic [1:0]                fq_dir     = 2'h0;
  logic [7:0]                mask_value = 8'h00;
  clc_pkg::clc_pld_cfg_s [1:0] pld_cfg  = '0;
  logic [1:0][11:0]          pld_in     = '0;
  logic [1:0][3:0]           pld_out;
  clc_pkg::clc_cond_s        cond;
  logic [1:0]                fq_empty;
  logic [1:0]                fq_full;
  int                        err_count  = 0;
  int                        check_count = 0;
  logic [7:0]                exp_q[$];
  logic [7:0]                val[5];
  logic [7:0]                a;
  logic [7:0]                b;
  clc_pkg::clc_dp_cfg_s      w;
  clc_pkg::clc_cond_s        ce;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk_sys = ~clk_sys;

  // ********
  // Instances
  // ********
  clc_bus_host i_clc_bus_host (.clk_sys(clk_sys), .bus_req(bus_req));
  clc_cell #(.FQ_DEPTH(clc_pkg::FQ_DEPTH)) i_clc_cell (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .dp_addr(dp_addr), .fq_dir(fq_dir), .mask_value(mask_value), .pld_cfg(pld_cfg),
    .pld_in(pld_in), .pld_out(pld_out), .cond(cond), .fq_empty(fq_empty), .fq_full(fq_full));

  // ********
  // Helpers
  // ********
  // Compares one value and counts the result.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bus write and read; a read notes its expected byte first.
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    i_clc_bus_host.access(1'b1, 1'b0, sel, d, $urandom_range(1, 0));
  endtask
  task automatic rd(input logic [2:0] sel, input logic [7:0] e);
    exp_q.push_back(e);
    i_clc_bus_host.access(1'b0, 1'b1, sel, 8'h00, $urandom_range(2, 0));
  endtask

  // Store write, and one datapath cycle on a given word before returning to idle word 7.
  task automatic store(input logic [2:0] adr, input clc_pkg::clc_dp_cfg_s d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= adr;
    cfg_data <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic step(input logic [2:0] adr);
    @(posedge clk_sys);
    dp_addr <= adr;
    @(posedge clk_sys);
    dp_addr <= 3'h7;
  endtask

  // Reference ALU result for operands x and y.
  function automatic logic [7:0] alu(input logic [2:0] f, input logic [7:0] x,
                                     input logic [7:0] y);
    case (f)
      3'h0: return x + 8'h01;
      3'h1: return x - 8'h01;
      3'h2: return x + y;
      3'h3: return x - y;
      3'h4: return x & y;
      3'h5: return x | y;
      3'h6: return x ^ y;
      default: return x;
    endcase
  endfunction

  // Reference carry or borrow out of the ALU for each function.
  function automatic logic carry(input logic [2:0] f, input logic [7:0] x, input logic [7:0] y);
    case (f)
      3'h0: return x == 8'hFF;
      3'h1: return x == 8'h00;
      3'h2: return (9'(x) + 9'(y)) > 9'h0FF;
      3'h3: return x < y;
      default: return 1'b0;
    endcase
  endfunction

  // Reference sum of products for one array.
  function automatic logic [3:0] pld_eval(input clc_pkg::clc_pld_cfg_s c, input logic [11:0] x);
    logic [7:0] term;
    logic [3:0] r;
    for (int t = 0; t < 8; t++) term[t] = &((x | ~c.pt_true[t]) & (~x | ~c.pt_comp[t]));
    for (int o = 0; o < 4; o++) r[o] = |(term & c.or_mask[o]);
    return r;
  endfunction

  // Read checker.
  // Each read answer is matched against the oldest noted byte.
  always @(negedge clk_sys) begin
    if (bus_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 16'h0001, 16'h0000);
      else check("bus_rdata", 16'(bus_rdata), 16'(exp_q.pop_front()));
    end
  end

  // A run that hangs counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    close_out();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(32'h0000_235b));
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < 8; t++) begin
        pld_cfg[k].pt_true[t] = 12'h001 << $urandom_range(11, 0);
        pld_cfg[k].pt_comp[t] = 12'h001 << $urandom_range(11, 0);
      end
      for (int o = 0; o < 4; o++) begin
        pld_cfg[k].or_mask[o] = (k == 1 && o == 2) ? 8'h01 : (8'($urandom()) | 8'h01);
      end
      pld_cfg[k].out_reg = (k == 1) ? 4'hF : 4'h0;
    end
    mask_value = 8'($urandom());
    repeat (10) @(posedge clk_sys);
    check("pld_reg_rst", 16'(pld_out[1]), 16'h0000);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("fq_empty_rst", 16'(fq_empty), 16'h0003);
    check("cond_rst", 16'(cond), 16'h0000);
    for (int s = 0; s < 8; s++) rd(3'(s), 8'h00);
    for (int s = 0; s < 4; s++) begin
      val[s] = 8'($urandom());
      wr(3'(s), val[s]);
    end
    for (int s = 0; s < 4; s++) rd(3'(s), val[s]);
    for (int f = 0; f < 8; f++) begin
      a = 8'($urandom());
      b = 8'($urandom());
      wr(3'h0, a);
      wr(3'h2, b);
      w = clc_pkg::CFG_RESET;
      w.func = clc_pkg::clc_func_e'(f);
      w.srcb = f[0] ? 2'h3 : 2'h2;
      w.alu_a0 = 1'b1;
      store(3'h1, w);
      step(3'h1);
      @(negedge clk_sys);
      check("alu_ovf", 16'(cond.ovf), 16'(carry(3'(f), a, f[0] ? val[3] : b)));
      rd(3'h0, alu(3'(f), a, f[0] ? val[3] : b));
      rd(3'h2, b);
    end
    w = clc_pkg::CFG_RESET;
    w.shl = 1'b1;
    w.swap = 1'b1;
    w.mask_en = 1'b1;
    w.alu_a1 = 1'b1;
    store(3'h0, w);
    step(3'h0);
    a = alu(3'h7, a, b) << 1;
    a = {a[3:0], a[7:4]} | mask_value;
    rd(3'h1, a);
    w = clc_pkg::CFG_RESET;
    w.shr = 1'b1;
    w.srca = 1'b1;
    w.alu_a0 = 1'b1;
    store(3'h4, w);
    step(3'h4);
    rd(3'h0, a >> 1);
    wr(3'h0, b);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("cmp_eq0", 16'(cond.cmp_eq[0]), 16'h0001);
    ce = '{ovf: 1'b0, ones: {a == 8'hFF, b == 8'hFF}, zero: {a == 8'h00, b == 8'h00},
           cmp_lt: {a < val[3], 1'b0}, cmp_eq: {a == val[3], 1'b1}};
    check("cond_all", 16'(cond), 16'(ce));
    for (int i = 0; i < 5; i++) begin
      val[i] = 8'($urandom());
      wr(3'h4, val[i]);
    end
    @(negedge clk_sys);
    check("fq_full0", 16'(fq_full[0]), 16'h0001);
    rd(3'h4, 8'h00);
    w = clc_pkg::CFG_RESET;
    w.f0_op = 1'b1;
    store(3'h2, w);
    for (int i = 0; i < 5; i++) begin
      step(3'h2);
      rd(3'h2, val[(i < 4) ? i : 3]);
    end
    @(negedge clk_sys);
    check("fq_empty0", 16'(fq_empty[0]), 16'h0001);
    val[4] = 8'($urandom());
    wr(3'h4, val[4]);
    w = clc_pkg::CFG_RESET;
    w.f0_op = 1'b1;
    w.f0_alt = 1'b1;
    store(3'h5, w);
    step(3'h5);
    rd(3'h0, val[4]);
    @(posedge clk_sys);
    fq_dir <= 2'h2;
    w = clc_pkg::CFG_RESET;
    w.f1_op = 1'b1;
    w.f1_alt = 1'b1;
    store(3'h3, w);
    for (int i = 0; i < 5; i++) begin
      val[i] = 8'($urandom());
      wr(3'h1, val[i]);
      step(3'h3);
    end
    @(negedge clk_sys);
    check("fq_full1", 16'(fq_full[1]), 16'h0001);
    wr(3'h5, 8'hA5);
    for (int i = 0; i < 5; i++) rd(3'h5, (i < 4) ? val[i] : 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      pld_in <= {12'($urandom()), 12'($urandom())};
      @(negedge clk_sys);
      check("pld_comb", 16'(pld_out[0]), 16'(pld_eval(pld_cfg[0], pld_in[0])));
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("pld_reg", 16'(pld_out[1]), 16'(pld_eval(pld_cfg[1], pld_in[1])));
    end
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clk_sys);
    if (exp_q.size() > 0) check("read drain", 16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule // clc_cell_bench
